/* pfr_pkg.sv */
// pid frequency regulator: shared constants and setting defaults
// assumes fixed-point settings in the documented minimum units
`default_nettype none
package pfr_pkg;
   // reference source codes
   typedef enum logic [2:0] {
      PFR_SRC_OFF,
      PFR_SRC_POT,
      PFR_SRC_PANEL,
      PFR_SRC_VOLT,
      PFR_SRC_CURR,
      PFR_SRC_COMM,
      PFR_SRC_ANADIG,
      PFR_SRC_SPEED
   } pfr_src_type;

   localparam int  PFR_DW           = 16;        // data width of inputs and output
   localparam int  PFR_AW           = 40;        // internal accumulator width
   localparam logic [15:0] PFR_GAIN_DEF     = 16'h05DC; // 1.500 in 0.001 units
   localparam logic [15:0] PFR_GAIN_MAX     = 16'h2710; // 10.000
   localparam logic [15:0] PFR_TIME_MAX     = 16'h2710; // 100.00 s in 0.01 s
   localparam logic [15:0] PFR_ADIG_MAX     = 16'h03E8; // 10.00 V in 0.01 V
   localparam logic [15:0] PFR_SPEED_MAX    = 16'h7530; // 30000 rpm
   localparam logic [7:0]  PFR_BAND_DEF     = 8'h14;    // 2.0 % in 0.1 %
   localparam logic [7:0]  PFR_BAND_MAX     = 8'hC8;    // 20.0 %
   localparam int  PFR_GAIN_SHIFT   = 10;        // approx /1000 scale of gain
   localparam int  PFR_BAND_DIV     = 1000;      // band in 0.1 % of reference
   localparam logic [PFR_AW-1:0] PFR_INT_LIM = 40'h7F_FFFF_FFFF; // numeric bound
endpackage
`default_nettype wire

/* pfr_regulator.sv */
// pid frequency regulator: reference/feedback select, pid terms, limits
// assumes all inputs synchronous to i_clk_sys and a sample tick from outside
`default_nettype none
module pfr_regulator
   import pfr_pkg::*;
#(
   parameter int DW = PFR_DW
) (
   input  wire logic          i_clk_sys,
   input  wire logic          i_rstn,
   input  wire logic          i_sample_tick,
   input  wire logic          i_load_settings,
   input  wire logic [2:0]    i_reference_source_select,
   input  wire logic          i_feedback_source_select,
   input  wire logic [15:0]   i_analog_digital_reference,
   input  wire logic [15:0]   i_speed_digital_reference,
   input  wire logic [15:0]   i_gain_setting,
   input  wire logic [15:0]   i_integral_constant_setting,
   input  wire logic [15:0]   i_derivative_constant_setting,
   input  wire logic [7:0]    i_deviation_dead_band,
   input  wire logic          i_anti_windup_mode,
   input  wire logic [DW-1:0] i_panel_pot,
   input  wire logic [DW-1:0] i_panel_digital,
   input  wire logic [DW-1:0] i_voltage_analog_input,
   input  wire logic [DW-1:0] i_current_analog_input,
   input  wire logic [DW-1:0] i_comm_reference,
   input  wire logic [DW-1:0] i_upper_frequency_limit,
   input  wire logic [DW-1:0] i_lower_frequency_limit,
   output logic [DW-1:0]      o_frequency,
   output logic               o_pid_active,
   output logic               o_sequencer_disable,
   output logic               o_in_dead_band
);
   localparam int AW = PFR_AW;

   typedef struct packed {
      logic [2:0]           ref_sel;
      logic                 fb_sel;
      logic [15:0]          adig;
      logic [15:0]          speed;
      logic [15:0]          gain;
      logic [15:0]          ti;
      logic [15:0]          td;
      logic [7:0]           band;
      logic                 awm;
      logic signed [AW-1:0] integ;
      logic signed [AW-1:0] dterm;
      logic signed [DW:0]   prev_err;
      logic [DW-1:0]        freq;
      logic                 active;
      logic                 seq_dis;
      logic                 in_band;
   } pfr_state_type;

   pfr_state_type st;
   pfr_state_type next_st;

   logic [DW-1:0]        ref_val;
   logic [DW-1:0]        fb_val;
   logic signed [DW:0]   err;
   logic [DW:0]          err_abs;
   logic [DW+8:0]        band_lim;
   logic                 band_hit;
   logic signed [AW-1:0] p_term;
   logic signed [AW-1:0] i_step;
   logic signed [AW-1:0] i_cand;
   logic                 i_block;
   logic signed [DW+1:0] err_delta;
   logic signed [AW-1:0] d_cand;
   logic signed [AW+1:0] sum;
   logic signed [AW+1:0] hi_lim;
   logic signed [AW+1:0] lo_lim;
   logic [DW-1:0]        clamp_freq;
   logic                 at_hi;
   logic                 at_lo;
   logic [15:0]          adig_cl;
   logic [15:0]          speed_cl;
   logic [15:0]          gain_cl;
   logic [15:0]          ti_cl;
   logic [15:0]          td_cl;
   logic [7:0]           band_cl;

   // reference mux; digital settings scaled into the shared range by caller
   always_comb begin
      unique case (pfr_src_type'(st.ref_sel))
         PFR_SRC_OFF:    ref_val = '0;
         PFR_SRC_POT:    ref_val = i_panel_pot;
         PFR_SRC_PANEL:  ref_val = i_panel_digital;
         PFR_SRC_VOLT:   ref_val = i_voltage_analog_input;
         PFR_SRC_CURR:   ref_val = i_current_analog_input;
         PFR_SRC_COMM:   ref_val = i_comm_reference;
         PFR_SRC_ANADIG: ref_val = DW'(st.adig);
         PFR_SRC_SPEED:  ref_val = DW'(st.speed);
      endcase
   end

   // out-of-range settings saturate at the top of their span instead of wrapping
   always_comb begin
      adig_cl  = i_analog_digital_reference;
      speed_cl = i_speed_digital_reference;
      gain_cl  = i_gain_setting;
      ti_cl    = i_integral_constant_setting;
      td_cl    = i_derivative_constant_setting;
      band_cl  = i_deviation_dead_band;
      if (adig_cl > PFR_ADIG_MAX) begin
         adig_cl = PFR_ADIG_MAX;
      end
      if (speed_cl > PFR_SPEED_MAX) begin
         speed_cl = PFR_SPEED_MAX;
      end
      if (gain_cl > PFR_GAIN_MAX) begin
         gain_cl = PFR_GAIN_MAX;
      end
      if (ti_cl > PFR_TIME_MAX) begin
         ti_cl = PFR_TIME_MAX;
      end
      if (td_cl > PFR_TIME_MAX) begin
         td_cl = PFR_TIME_MAX;
      end
      if (band_cl > PFR_BAND_MAX) begin
         band_cl = PFR_BAND_MAX;
      end
   end

   always_comb begin
      fb_val    = st.fb_sel ? i_voltage_analog_input : i_current_analog_input;
      err       = $signed({1'b0, ref_val}) - $signed({1'b0, fb_val});
      err_abs   = err[DW] ? (DW+1)'(-err) : err;
      band_lim  = (DW+9)'((32'(ref_val) * 32'(st.band)) / PFR_BAND_DIV);
      band_hit  = ({8'h00, err_abs} <= band_lim);
      p_term    = AW'((($signed({1'b0, st.gain}) * err)) >>> PFR_GAIN_SHIFT);
      // integral step err*T/Ti, with T folded into the tick and Ti in 0.01 s units
      i_step    = (st.ti == '0) ? '0 : AW'(($signed(err) <<< 8) / $signed({1'b0, st.ti}));
      err_delta = (DW+2)'(err) - (DW+2)'(st.prev_err);
      d_cand    = AW'((err_delta * $signed({1'b0, st.td})) >>> 4);
      hi_lim    = (AW+2)'($signed({1'b0, i_upper_frequency_limit}));
      lo_lim    = (AW+2)'($signed({1'b0, i_lower_frequency_limit}));
      // the integrator saturates at its own bound rather than wrapping
      i_cand    = st.integ + i_step;
      if (i_step > 0 && i_cand < st.integ) begin
         i_cand = PFR_INT_LIM;
      end
      if (i_step < 0 && i_cand > st.integ) begin
         i_cand = ~PFR_INT_LIM;
      end
      at_hi     = (st.freq >= i_upper_frequency_limit);
      at_lo     = (st.freq <= i_lower_frequency_limit);
      // mode 0 only blocks the push further past a limit, so a reversal acts at once
      i_block   = !st.awm && ((at_hi && i_step > 0) || (at_lo && i_step < 0));
      // two guard bits: a saturated integrator plus p and d cannot wrap the sum
      sum       = (AW+2)'(p_term) + (AW+2)'(st.integ) + (AW+2)'(st.dterm);
      if (sum > hi_lim) begin
         clamp_freq = i_upper_frequency_limit;
      end else if (sum < lo_lim) begin
         clamp_freq = i_lower_frequency_limit;
      end else begin
         clamp_freq = DW'(sum);
      end
   end

   always_comb begin
      next_st         = st;
      next_st.active  = (st.ref_sel != 3'h0);
      next_st.seq_dis = (st.ref_sel != 3'h0);
      if (i_load_settings) begin
         next_st.ref_sel = i_reference_source_select;
         next_st.fb_sel  = i_feedback_source_select;
         next_st.adig    = adig_cl;
         next_st.speed   = speed_cl;
         next_st.gain    = gain_cl;
         next_st.ti      = ti_cl;
         next_st.td      = td_cl;
         next_st.band    = band_cl;
         next_st.awm     = i_anti_windup_mode;
      end
      // derivative cleared at once when disabled, even on the edge storing a zero time
      if (st.td == '0 || (i_load_settings && td_cl == '0)) begin
         next_st.dterm = '0;
      end
      if (i_sample_tick && st.active) begin
         next_st.in_band  = band_hit;
         next_st.prev_err = err;
         if (!band_hit) begin
            // ti zero gives no step, so the integrator simply holds
            if (st.ti != '0 && !i_block) begin
               next_st.integ = i_cand;
            end
            if (st.td != '0 && !(i_load_settings && td_cl == '0)) begin
               next_st.dterm = d_cand;
            end
            next_st.freq = clamp_freq;
         end
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         st      <= '0;
         st.gain <= PFR_GAIN_DEF;
         st.band <= PFR_BAND_DEF;
      end else begin
         st <= next_st;
      end
   end

   assign o_frequency         = st.freq;
   assign o_pid_active        = st.active;
   assign o_sequencer_disable = st.seq_dis;
   assign o_in_dead_band      = st.in_band;
endmodule
`default_nettype wire

/* pfr_regulator_props.sv */
// checker: timing relations seen at the pid regulator ports
// assumes one clock domain; bound into every pfr_regulator
`default_nettype none
module pfr_regulator_chk #(parameter int DW = 16) (
   input wire logic          i_clk_sys,
   input wire logic          i_rstn,
   input wire logic          i_sample_tick,
   input wire logic          i_load_settings,
   input wire logic [2:0]    i_reference_source_select,
   input wire logic [DW-1:0] i_upper_frequency_limit,
   input wire logic [DW-1:0] i_lower_frequency_limit,
   input wire logic [DW-1:0] o_frequency,
   input wire logic          o_pid_active,
   input wire logic          o_sequencer_disable,
   input wire logic          o_in_dead_band
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   wire logic upd = i_sample_tick && o_pid_active;
   chk_seq_mirror: assert property (o_sequencer_disable == o_pid_active)
      else $error("sequencer disable differs from pid active");
   chk_clamp_high: assert property (upd |=> o_frequency <= $past(i_upper_frequency_limit))
      else $error("frequency above upper limit");
   chk_clamp_low: assert property (upd |=> o_frequency >= $past(i_lower_frequency_limit))
      else $error("frequency below lower limit");
   chk_freq_hold: assert property (!upd |=> $stable(o_frequency))
      else $error("frequency moved without an active tick");
   chk_band_hold: assert property (!upd |=> $stable(o_in_dead_band))
      else $error("dead band flag moved without an active tick");
   chk_band_freeze: assert property (upd |=> (o_in_dead_band -> $stable(o_frequency)))
      else $error("frequency moved inside dead band");
   chk_active_load: assert property (i_load_settings ##1 !i_load_settings |->
      ##1 (o_pid_active == ($past(i_reference_source_select, 2) != 3'h0)))
      else $error("pid active does not follow stored selector");
   // must see outputs while reset is low, so no disable here
   chk_reset_clear: assert property (disable iff (1'b0)
      !i_rstn |-> (o_frequency == '0) && !o_pid_active && !o_in_dead_band)
      else $error("outputs not cleared in reset");
   cover property (upd && o_in_dead_band);
   cover property (upd ##1 o_frequency == i_upper_frequency_limit);
   cover property ($rose(o_pid_active));
endmodule
bind pfr_regulator pfr_regulator_chk #(.DW(DW)) u_chk (.*);
`default_nettype wire

/* pfr_plant.sv */
// plant model: sample tick source and analog feedback front end
// assumes levels set by the bench; analog inputs lag them by one clock
`default_nettype none
module pfr_plant #(parameter int PERIOD = 4) (
   input  wire logic        i_clk_sys,
   input  wire logic        i_run,
   input  wire logic [15:0] i_vlvl,
   input  wire logic [15:0] i_clvl,
   output var  logic        o_tick = 1'b0,
   output var  logic [15:0] o_volt = 16'h0000,
   output var  logic [15:0] o_curr = 16'h0000
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   // short period keeps runs brief; still far under a fifth of any time constant
   always @(posedge i_clk_sys) begin
      cnt    <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      o_tick <= i_run && cnt == 0;
      o_volt <= i_vlvl;
      o_curr <= i_clvl;
   end
endmodule
`default_nettype wire

/* pfr_regulator_tb.sv */
// self-checking bench for the pid frequency regulator
// assumes pfr_plant supplies ticks and feedback levels
`default_nettype none
module pfr_regulator_tb
   import pfr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk_sys = 0, i_rstn, i_load_settings = 0, i_feedback_source_select = 0;
   logic i_anti_windup_mode = 0, run = 0;
   logic [2:0]  i_reference_source_select = 3'h0;
   logic [7:0]  i_deviation_dead_band = 8'h14;
   logic [15:0] i_analog_digital_reference = 16'h0258, i_speed_digital_reference = 16'h02BC;
   logic [15:0] i_gain_setting = 16'h05DC, i_integral_constant_setting = 16'h0000;
   logic [15:0] i_derivative_constant_setting = 16'h0000, i_panel_pot = 16'h0064;
   logic [15:0] i_panel_digital = 16'h00C8, i_comm_reference = 16'h01F4;
   logic [15:0] i_upper_frequency_limit = 16'hFFFF, i_lower_frequency_limit = 16'h0000;
   logic [15:0] vlvl = 16'h012C, clvl = 16'h0000;
   logic [15:0] refv [8] = '{16'h0, 16'h64, 16'hC8, 16'h12C, 16'h0, 16'h1F4, 16'h258, 16'h2BC};
   wire logic   i_sample_tick, o_pid_active, o_sequencer_disable, o_in_dead_band;
   wire logic [15:0] i_voltage_analog_input, i_current_analog_input, o_frequency;
   int err_count = 0, total_checks = 0, cyc = 0;
   pfr_regulator dut (.*);
   pfr_plant plant (.i_clk_sys, .i_run(run), .i_vlvl(vlvl), .i_clvl(clvl),
      .o_tick(i_sample_tick), .o_volt(i_voltage_analog_input), .o_curr(i_current_analog_input));
   initial forever #2 i_clk_sys = ~i_clk_sys;
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         final_report();
      end
   end
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // settings are captured whole; load restates selector, feedback, gain, Ti and mode, the rest keep their bench values
   task automatic load(logic [2:0] s, logic f, logic [15:0] g, logic [15:0] t, logic m);
      @(posedge i_clk_sys);
      i_reference_source_select <= s;
      i_feedback_source_select <= f;
      i_gain_setting <= g;
      i_integral_constant_setting <= t;
      i_anti_windup_mode <= m;
      i_load_settings <= 1'b1;
      @(posedge i_clk_sys);
      i_load_settings <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
   endtask
   task automatic ticks(int n);
      repeat (n) @(posedge i_clk_sys iff i_sample_tick);
      @(posedge i_clk_sys);
   endtask
   initial begin
      // a real falling edge at time zero, so the async branch clears state before any edge
      i_rstn <= 1'b0;
      repeat (5) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      run <= 1'b1;
      ticks(2);
      check("freq_idle", o_frequency, 16'h0000);
      check("active_idle", o_pid_active, 1'b0);
      for (int c = 1; c < 8; c++) begin
         clvl <= refv[c];
         load(c[2:0], 1'b0, 16'h05DC, 16'h0000, 1'b0);
         ticks(2);
         check("band_src", o_in_dead_band, 1'b1);
         check("seq_off", o_sequencer_disable, 1'b1);
      end
      i_analog_digital_reference <= 16'hFFFF;
      clvl <= 16'h03E8;
      load(3'h6, 1'b0, 16'h05DC, 16'h0000, 1'b0);
      ticks(2);
      check("adig_clamp", o_in_dead_band, 1'b1);
      i_analog_digital_reference <= 16'h0258;
      clvl <= 16'h0000;
      load(3'h3, 1'b1, 16'h05DC, 16'h0000, 1'b0);
      ticks(2);
      check("fb_volt", o_in_dead_band, 1'b1);
      load(3'h7, 1'b1, 16'h05DC, 16'h0000, 1'b0);
      ticks(2);
      check("fb_far", o_in_dead_band, 1'b0);
      load(3'h0, 1'b0, 16'h05DC, 16'h0000, 1'b0);
      check("pid_off", o_pid_active, 1'b0);
      $display("test sources done");
      i_upper_frequency_limit <= 16'h0032;
      i_lower_frequency_limit <= 16'h000A;
      load(3'h6, 1'b0, PFR_GAIN_MAX, 16'h0000, 1'b0);
      ticks(3);
      check("clamp_hi", o_frequency, 16'h0032);
      i_analog_digital_reference <= 16'h0000;
      clvl <= 16'h02BC;
      ticks(4);
      check("clamp_lo", o_frequency, 16'h000A);
      $display("test clamp done");
      for (int m = 0; m < 2; m++) begin
         i_speed_digital_reference <= 16'h02BC;
         clvl <= 16'h0000;
         load(3'h7, 1'b0, 16'h0000, 16'h2710, m[0]);
         ticks(40);
         check("wind_up", o_frequency, 16'h0032);
         // deep reversal: mode 0 leaves the limit within two ticks, mode 1 cannot
         clvl <= 16'h0FFF;
         ticks(3);
         check("unwind", {15'h0, o_frequency < 16'h0032}, {15'h0, !m[0]});
      end
      $display("test windup done");
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      check("rst_freq", o_frequency, 16'h0000);
      i_rstn <= 1'b1;
      ticks(2);
      check("rst_sel", o_pid_active, 1'b0);
      $display("test reset done");
      i_derivative_constant_setting <= 16'h0010;
      clvl <= 16'h0200;
      load(3'h7, 1'b0, 16'h0000, 16'h0000, 1'b0);
      ticks(3);
      check("d_settle", o_frequency, 16'h000A);
      clvl <= 16'h0000;
      ticks(2);
      check("d_kick", o_frequency, 16'h0032);
      clvl <= 16'h0200;
      ticks(2);
      clvl <= 16'h0000;
      i_derivative_constant_setting <= 16'h0000;
      ticks(1);
      load(3'h7, 1'b0, 16'h0000, 16'h0000, 1'b0);
      check("d_clear", o_frequency, 16'h000A);
      $display("test derivative done");
      final_report();
   end
endmodule
`default_nettype wire
